// ===== shared/wdt_pkg.sv
// Behaviour
// - watchdog enabled and counting after reset
// - overflow action defaults to reset, changeable once
// - overflow with action 1 drives reset pin low
// - overflow with action 0 raises watchdog interrupt
// - counting pauses in stop and idle
// - clear code clears binary counter, not divider
// - two-bit period select, fast or slow clock
// - after action 0, writes of 1 ignored
// - control register write-only, reads as zero
// - control register resets to 11 1001
// - disable code works only with enable bit 0
// - command codes: clear, disable, trap arm
// - interrupt action gives periodic interrupt
// - binary counters held cleared while disabled
// - watchdog interrupt is non-maskable
// - reset pin driven low at most 24 fast periods
package wdt_pkg;

    // register offsets on the plain register port
    localparam logic [7:0] OFF_CTRL_FIRST = 8'h34;
    localparam logic [7:0] OFF_CMD_PORT = 8'h35;
    localparam logic [7:0] OFF_STATUS = 8'h3f;

    // command codes
    localparam logic [7:0] CMD_CLEAR = 8'h4e;
    localparam logic [7:0] CMD_DISABLE = 8'hb1;
    localparam logic [7:0] CMD_TRAP_ARM = 8'hd2;

    // control register fields
    localparam int CTL_ACTION_BIT = 0;
    localparam int CTL_TIME_LSB = 1;
    localparam int CTL_ENABLE_BIT = 3;
    localparam int CTL_TRAP_ACT_BIT = 4;
    localparam int CTL_TRAP_AREA_BIT = 5;
    localparam logic [5:0] CTL_RESET = 6'h39;

    // status register fields
    localparam int ST_RUN_BIT = 0;
    localparam int ST_ACTION_BIT = 1;
    localparam int ST_CNT_LSB = 2;
    localparam int ST_RST_BIT = 4;
    localparam int ST_PIN_BIT = 5;
    localparam int ST_ARMED_BIT = 6;
    localparam int ST_OVF_BIT = 7;

    // reset pulse length: figure in fast-clock periods, converted to cycles
    localparam int CLK_HZ = 25000000;
    localparam int FC_HZ = 25000000;
    localparam int RST_FC_PERIODS = 24;
    localparam int RST_CYC_RAW = (RST_FC_PERIODS * (CLK_HZ / 1000)) / (FC_HZ / 1000);
    localparam int RST_CYCLES = (RST_CYC_RAW < 1) ? 1 : RST_CYC_RAW;
    localparam logic [4:0] RST_LAST = 5'(RST_CYCLES - 1);

    // top-level state
    typedef enum logic [2:0] {
        WDT_OFF = 3'b001,
        WDT_RUN = 3'b010,
        WDT_RST = 3'b100
    } wdt_state_t;

endpackage

// ===== core/wdt_divtap.sv
`timescale 1ns/1ps
// free-running divider with a tap chosen two bits at a time
module wdt_divtap #(
    parameter int W = 23
) (
    // clock and reset
    input wire logic clock,
    input wire logic srst,
    // control
    input wire logic en,
    input wire logic [1:0] sel,
    // tick out, one cycle per wrap of the selected low bits
    output logic tick
);

    logic [W-1:0] div_q;
    logic [W-1:0] div_d;
    logic [W-1:0] mask;

    // each select step shortens the period by a factor of four
    assign mask = {W{1'b1}} >> {sel, 1'b0};
    assign div_d = en ? div_q + W'(1) : div_q;
    assign tick = en && ((div_q & mask) == mask);

    // never cleared by the clear code, only by chip reset
    always_ff @(posedge clock) begin
        if (srst) begin
            div_q <= '0;
        end else begin
            div_q <= div_d;
        end
    end

endmodule // wdt_divtap

// ===== core/wdt_core.sv
`timescale 1ns/1ps
module wdt_core #(
    parameter int FC_DIV_W = 23,
    parameter int FS_DIV_W = 15
) (
    // clock and reset
    input wire logic clock,
    input wire logic srst,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // clock source and power modes
    input wire logic low_freq_tick,
    input wire logic slow_mode,
    input wire logic slow_prescale_select,
    input wire logic stop_mode,
    input wire logic idle_mode,
    // overflow actions
    output logic watchdog_interrupt_request,
    output logic reset_pin_o,
    output logic reset_pin_oe,
    input wire logic reset_pin_i,
    // settings for the address-trap logic
    output logic trap_area_select,
    output logic trap_action_select,
    output logic trap_area_armed
);

    // control register state
    logic watchdog_enable_bit_q;
    logic watchdog_enable_bit_d;
    logic [1:0] detection_time_select_q;
    logic [1:0] detection_time_select_d;
    logic overflow_action_select_q;
    logic overflow_action_select_d;
    logic trap_area_q;
    logic trap_area_d;
    logic trap_action_q;
    logic trap_action_d;
    logic trap_armed_q;
    logic trap_armed_d;

    // run state, counter and status
    logic run_q;
    logic run_d;
    logic [1:0] bin_cnt_q;
    logic [1:0] bin_cnt_d;
    logic ovf_seen_q;
    logic ovf_seen_d;
    logic [4:0] rst_cnt_q;
    logic [4:0] rst_cnt_d;
    wdt_pkg::wdt_state_t state_q;
    wdt_pkg::wdt_state_t state_d;

    // registered outputs
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;
    logic irq_q;
    logic pin_oe_q;
    logic pin_o_q;

    // decode wires
    logic wr_ctrl;
    logic wr_cmd;
    logic rd_status;
    logic cmd_clear;
    logic cmd_disable;
    logic cmd_arm;
    logic use_slow;
    logic count_en;
    logic fc_en;
    logic fs_en;
    logic fc_tick;
    logic fs_tick;
    logic tick;
    logic ovf;
    logic rst_done;
    logic [7:0] status_word;

    // address decode of the plain register port
    assign wr_ctrl = reg_wr && (reg_addr == wdt_pkg::OFF_CTRL_FIRST);
    assign wr_cmd = reg_wr && (reg_addr == wdt_pkg::OFF_CMD_PORT);
    assign rd_status = reg_rd && (reg_addr == wdt_pkg::OFF_STATUS);

    // command decode; every other value written is dropped
    assign cmd_clear = wr_cmd && (reg_wdata == wdt_pkg::CMD_CLEAR);
    assign cmd_disable = wr_cmd && (reg_wdata == wdt_pkg::CMD_DISABLE);
    assign cmd_arm = wr_cmd && (reg_wdata == wdt_pkg::CMD_TRAP_ARM);

    // control register: plain fields load on write
    assign detection_time_select_d = wr_ctrl ?
        reg_wdata[wdt_pkg::CTL_TIME_LSB +: 2] : detection_time_select_q;
    assign watchdog_enable_bit_d = wr_ctrl ?
        reg_wdata[wdt_pkg::CTL_ENABLE_BIT] : watchdog_enable_bit_q;
    assign trap_area_d = wr_ctrl ? reg_wdata[wdt_pkg::CTL_TRAP_AREA_BIT] : trap_area_q;
    assign trap_action_d = wr_ctrl ? reg_wdata[wdt_pkg::CTL_TRAP_ACT_BIT] : trap_action_q;

    // action bit can only fall: once at 0 it stays until reset
    assign overflow_action_select_d = wr_ctrl ?
        (overflow_action_select_q & reg_wdata[wdt_pkg::CTL_ACTION_BIT]) :
        overflow_action_select_q;

    // armed area takes the area choice only when the arm code follows it; trap_area_select shows it at once
    assign trap_armed_d = cmd_arm ? trap_area_q : trap_armed_q;

    // enable bit 1 starts the timer; disable code only acts with bit already 0
    assign run_d = (wr_ctrl && reg_wdata[wdt_pkg::CTL_ENABLE_BIT]) ? 1'b1 :
        (cmd_disable && !watchdog_enable_bit_q) ? 1'b0 : run_q;

    // slow source when prescale select set or in slow mode
    assign use_slow = slow_mode || slow_prescale_select;

    // counting stalls in low-power modes and resumes from the held count
    assign count_en = (state_q == wdt_pkg::WDT_RUN) && run_q &&
        !stop_mode && !idle_mode;
    assign fc_en = count_en && !use_slow;
    assign fs_en = count_en && use_slow && low_freq_tick;

    // fast-clock divider: quarter period 2^23 down to 2^17
    wdt_divtap #(
        .W(FC_DIV_W)
    ) u_fc_div (
        .clock(clock),
        .srst(srst),
        .en(fc_en),
        .sel(detection_time_select_q),
        .tick(fc_tick)
    );

    // slow-clock divider: quarter period 2^15 down to 2^9
    wdt_divtap #(
        .W(FS_DIV_W)
    ) u_fs_div (
        .clock(clock),
        .srst(srst),
        .en(fs_en),
        .sel(detection_time_select_q),
        .tick(fs_tick)
    );

    // four quarter ticks overflow the counter, so the first may come at 3/4
    assign tick = fc_tick || fs_tick;

    // overflow of the two-stage counter; a clear in the same cycle wins
    assign ovf = tick && (bin_cnt_q == 2'h3) && !cmd_clear && run_q &&
        (state_q == wdt_pkg::WDT_RUN);

    // binary counter: clear code and disabled state zero it, divider untouched
    always_comb begin
        bin_cnt_d = bin_cnt_q;
        if (!run_q || state_q != wdt_pkg::WDT_RUN) begin
            bin_cnt_d = 2'h0;
        end else if (cmd_clear) begin
            bin_cnt_d = 2'h0;
        end else if (tick) begin
            bin_cnt_d = bin_cnt_q + 2'h1;
        end
    end

    // reset pulse length counter
    assign rst_done = (rst_cnt_q == wdt_pkg::RST_LAST);
    assign rst_cnt_d = (state_q == wdt_pkg::WDT_RST) ? rst_cnt_q + 5'h1 : 5'h0;

    // sequencing of run, off and reset drive
    always_comb begin
        state_d = state_q;
        case (state_q)
            wdt_pkg::WDT_OFF: begin
                if (run_d) begin
                    state_d = wdt_pkg::WDT_RUN;
                end
            end
            wdt_pkg::WDT_RUN: begin
                if (ovf && overflow_action_select_q) begin
                    state_d = wdt_pkg::WDT_RST;
                end else if (!run_d) begin
                    state_d = wdt_pkg::WDT_OFF;
                end
            end
            wdt_pkg::WDT_RST: begin
                if (rst_done) begin
                    state_d = run_d ? wdt_pkg::WDT_RUN : wdt_pkg::WDT_OFF;
                end
            end
            default: begin
                state_d = wdt_pkg::WDT_OFF;
            end
        endcase
    end

    // sticky overflow flag, read clears it; a new overflow beats the clear
    assign ovf_seen_d = ovf ? 1'b1 : (rd_status ? 1'b0 : ovf_seen_q);

    // status view of the block's state and the reset pin level
    assign status_word = {
        ovf_seen_q,
        trap_armed_q,
        reset_pin_i,
        pin_oe_q,
        bin_cnt_q,
        overflow_action_select_q,
        run_q
    };

    // control and command registers are write-only and read as zero
    assign rdata_d = rd_status ? status_word : 8'h00;

    // control register flops; reset pattern is 11 1001
    always_ff @(posedge clock) begin
        if (srst) begin
            overflow_action_select_q <= wdt_pkg::CTL_RESET[wdt_pkg::CTL_ACTION_BIT];
            detection_time_select_q <= wdt_pkg::CTL_RESET[wdt_pkg::CTL_TIME_LSB +: 2];
            watchdog_enable_bit_q <= wdt_pkg::CTL_RESET[wdt_pkg::CTL_ENABLE_BIT];
            trap_action_q <= wdt_pkg::CTL_RESET[wdt_pkg::CTL_TRAP_ACT_BIT];
            trap_area_q <= wdt_pkg::CTL_RESET[wdt_pkg::CTL_TRAP_AREA_BIT];
        end else begin
            overflow_action_select_q <= overflow_action_select_d;
            detection_time_select_q <= detection_time_select_d;
            watchdog_enable_bit_q <= watchdog_enable_bit_d;
            trap_action_q <= trap_action_d;
            trap_area_q <= trap_area_d;
        end
    end

    // run state: up and counting straight out of reset
    always_ff @(posedge clock) begin
        if (srst) begin
            run_q <= 1'b1;
            state_q <= wdt_pkg::WDT_RUN;
        end else begin
            run_q <= run_d;
            state_q <= state_d;
        end
    end

    // counters and sticky flags
    always_ff @(posedge clock) begin
        if (srst) begin
            bin_cnt_q <= 2'h0;
            rst_cnt_q <= 5'h0;
            ovf_seen_q <= 1'b0;
            trap_armed_q <= 1'b0;
        end else begin
            bin_cnt_q <= bin_cnt_d;
            rst_cnt_q <= rst_cnt_d;
            ovf_seen_q <= ovf_seen_d;
            trap_armed_q <= trap_armed_d;
        end
    end

    // outputs: interrupt is a one-cycle pulse with no mask in its path
    always_ff @(posedge clock) begin
        if (srst) begin
            irq_q <= 1'b0;
            pin_oe_q <= 1'b0;
            pin_o_q <= 1'b0;
            rdata_q <= 8'h00;
        end else begin
            irq_q <= ovf && !overflow_action_select_q;
            pin_oe_q <= (state_d == wdt_pkg::WDT_RST);
            pin_o_q <= 1'b0;
            rdata_q <= rdata_d;
        end
    end

    // the pin is open-drain: only ever pulled low
    assign reset_pin_o = pin_o_q;
    assign reset_pin_oe = pin_oe_q;
    assign watchdog_interrupt_request = irq_q;
    assign reg_rdata = rdata_q;
    assign trap_area_select = trap_area_q;
    assign trap_action_select = trap_action_q;
    assign trap_area_armed = trap_armed_q;

endmodule // wdt_core

// ===== verif/wdt_checker.sv
`timescale 1ns/1ps
// sees the core's pins only; the drive length is counted here
module wdt_checker (
    // clock and reset
    input wire logic clock,
    input wire logic srst,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    // modes and outputs
    input wire logic stop_mode,
    input wire logic idle_mode,
    input wire logic watchdog_interrupt_request,
    input wire logic reset_pin_o,
    input wire logic reset_pin_oe,
    input wire logic trap_area_select,
    input wire logic trap_action_select,
    input wire logic trap_area_armed
);
    logic [4:0] oe_cnt_q;
    default clocking
        @(posedge clock);
    endclocking
    default disable iff (srst);
    // cycles of the current reset drive; holds the total for the first idle cycle, then zero
    always_ff @(posedge clock) begin
        if (srst || !reset_pin_oe) begin
            oe_cnt_q <= 5'h00;
        end else begin
            oe_cnt_q <= oe_cnt_q + 5'h01;
        end
    end
    // clear code taken on the command port
    sequence s_clear;
        reg_wr && reg_addr == wdt_pkg::OFF_CMD_PORT && reg_wdata == wdt_pkg::CMD_CLEAR;
    endsequence
    // four quarter ticks need at least seven cycles even at the shortest tap
    sequence s_quiet;
        (!watchdog_interrupt_request && !$rose(reset_pin_oe)) [*7];
    endsequence
    chk_irq_pulse: assert property (watchdog_interrupt_request |=> !watchdog_interrupt_request)
        else $error("irq pulse too long");
    chk_pin_low: assert property (reset_pin_oe |-> !reset_pin_o)
        else $error("reset pin not low");
    chk_drive_max: assert property (reset_pin_oe |-> oe_cnt_q < 5'h18)
        else $error("reset drive too long");
    chk_drive_len: assert property ($fell(reset_pin_oe) |-> oe_cnt_q == 5'h18)
        else $error("reset drive length wrong");
    chk_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data outside slot");
    chk_ctrl_unread: assert property ($past(reg_rd) && $past(reg_addr) == wdt_pkg::OFF_CTRL_FIRST
        |-> reg_rdata == 8'h00)
        else $error("control read not zero");
    chk_frozen_quiet: assert property ($past(stop_mode) || $past(idle_mode)
        |-> !watchdog_interrupt_request && !$rose(reset_pin_oe))
        else $error("overflow while frozen");
    chk_clear_hold: assert property (s_clear |=> s_quiet)
        else $error("overflow soon after clear");
    chk_trap_reset: assert property ($fell(srst)
        |-> trap_area_select && trap_action_select && !trap_area_armed)
        else $error("trap fields reset wrong");
endmodule // wdt_checker

// ===== verif/testbench.sv
`timescale 1ns/1ps
module testbench;
    localparam int FW = 7;
    localparam logic [7:0] CT = wdt_pkg::OFF_CTRL_FIRST;
    localparam logic [7:0] CM = wdt_pkg::OFF_CMD_PORT;
    localparam logic [7:0] ST = wdt_pkg::OFF_STATUS;
    localparam logic [7:0] CLR = wdt_pkg::CMD_CLEAR;
    logic clock = 1'b0;
    logic srst = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic low_freq_tick = 1'b0;
    logic sps = 1'b0;
    logic stop_mode = 1'b0;
    logic idle_mode = 1'b0;
    logic slow = 1'b0;
    logic lf_on = 1'b0;
    logic [1:0] lf_cnt = 2'h0;
    logic [7:0] reg_rdata;
    logic irq;
    logic pin_o;
    logic pin_oe;
    logic area;
    logic act;
    logic armed;
    logic [7:0] probe [3] = '{8'h34, 8'h35, 8'h00};
    int fails = 0;
    int n_checks = 0;
    int n;
    wire pin_i = pin_oe ? pin_o : 1'b1; // reset line has a pull-up
    // 25 MHz system clock
    always #20 clock = ~clock;
    // slow source: one enable pulse every third cycle
    always @(posedge clock) begin
        lf_cnt <= (lf_cnt == 2'h2) ? 2'h0 : lf_cnt + 2'h1;
        low_freq_tick <= lf_on && lf_cnt == 2'h2;
    end
    wdt_core #(.FC_DIV_W(FW), .FS_DIV_W(FW)) u_dut (
        .clock(clock), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .low_freq_tick(low_freq_tick), .slow_mode(slow), .slow_prescale_select(sps),
        .stop_mode(stop_mode), .idle_mode(idle_mode), .watchdog_interrupt_request(irq),
        .reset_pin_o(pin_o), .reset_pin_oe(pin_oe), .reset_pin_i(pin_i),
        .trap_area_select(area), .trap_action_select(act), .trap_area_armed(armed)
    );
    task automatic end_of_test();
        $display("checks %0d fails %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic check(input string name, input logic [7:0] e, input logic [7:0] g);
        n_checks++;
        if (g !== e) begin
            fails++;
            $display("wrong value %s expected %h seen %h", name, e, g);
        end
    endtask
    // a gap cycle follows each strobe so no signal is set twice in one step
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
        @(posedge clock);
    endtask
    task automatic rd_chk(input string s, input logic [7:0] a, m, e);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1;
        check(s, e, reg_rdata & m);
        @(posedge clock);
    endtask
    // waits for the interrupt (sel 1) or the reset drive (sel 0); n counts edges
    task automatic wait_sig(input logic sel, input int lim);
        n = 0;
        do begin
            @(posedge clock);
            #1;
            n++;
        end while ((sel ? irq : pin_oe) !== 1'b1 && n < lim);
        if ((sel ? irq : pin_oe) !== 1'b1) begin
            check("wait limit", 8'h00, 8'h01);
            end_of_test();
        end
        @(posedge clock);
    endtask
    // clear as soon as counting resumes, else the short period overflows again at once
    task automatic ovf_tail();
        wait_sig(1'b0, 12);
        repeat (24) @(posedge clock);
        wr(CM, CLR);
        rd_chk("drive over", ST, 8'h90, 8'h80);
    endtask
    initial begin
        repeat (16) @(posedge clock);
        srst <= 1'b0;
        @(posedge clock);
        rd_chk("status", ST, 8'hff, 8'h23);
        check("trap bits", 8'h03, {6'h00, area, act});
        foreach (probe[i]) rd_chk("unread", probe[i], 8'hff, 8'h00);
        wait_sig(1'b0, 600);
        check("first overflow", 8'h01, 8'((n > 370) && (n < 520)));
        n = 1;
        repeat (40) begin
            #1;
            n += (pin_oe === 1'b1) ? 1 : 0;
            @(posedge clock);
        end
        check("drive length", 8'h18, 8'(n));
        rd_chk("after drive", ST, 8'hf3, 8'ha3);
        wr(CT, 8'h3f);
        repeat (15) begin
            wr(CM, CLR);
            @(posedge clock);
        end
        rd_chk("kept alive", ST, 8'h90, 8'h00);
        ovf_tail();
        for (int i = 0; i < 2; i++) begin
            wr(CM, CLR);
            stop_mode <= (i == 0);
            idle_mode <= (i == 1);
            repeat (40) @(posedge clock);
            stop_mode <= 1'b0;
            idle_mode <= 1'b0;
            rd_chk("frozen", ST, 8'h90, 8'h00);
            ovf_tail();
        end
        wr(CT, 8'h3e);
        wait_sig(1'b1, 12);
        wait_sig(1'b1, 12);
        check("irq period", 8'h07, 8'(n));
        // the two middle period codes, each a factor of four apart
        for (int i = 1; i < 3; i++) begin
            wr(CT, 8'h38 | 8'(2 * i));
            wait_sig(1'b1, 140);
            wait_sig(1'b1, 140);
            check("code period", 8'((512 >> (2 * i)) - 1), 8'(n));
        end
        wr(CT, 8'h3f);
        wait_sig(1'b1, 12);
        rd_chk("action kept", ST, 8'h12, 8'h00);
        wr(CM, wdt_pkg::CMD_DISABLE);
        rd_chk("still on", ST, 8'h01, 8'h01);
        wr(CM, CLR);
        wr(CT, 8'h36);
        wr(CM, wdt_pkg::CMD_DISABLE);
        repeat (20) @(posedge clock);
        rd_chk("disabled", ST, 8'h0d, 8'h00);
        wr(CM, 8'h55);
        check("unknown code", 8'h00, {7'h00, armed});
        wr(CM, wdt_pkg::CMD_TRAP_ARM);
        check("trap armed", 8'h01, {7'h00, armed});
        sps <= 1'b1;
        lf_on <= 1'b1;
        wr(CT, 8'h3e);
        wait_sig(1'b1, 60);
        wait_sig(1'b1, 60);
        check("slow period", 8'h17, 8'(n));
        sps <= 1'b0;
        slow <= 1'b1;
        wait_sig(1'b1, 60);
        wait_sig(1'b1, 60);
        check("slow mode period", 8'h17, 8'(n));
        end_of_test();
    end
endmodule // testbench
bind wdt_core wdt_checker u_chk (
    .clock(clock), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .stop_mode(stop_mode), .idle_mode(idle_mode),
    .watchdog_interrupt_request(watchdog_interrupt_request), .reset_pin_o(reset_pin_o),
    .reset_pin_oe(reset_pin_oe), .trap_area_select(trap_area_select),
    .trap_action_select(trap_action_select), .trap_area_armed(trap_area_armed)
);
